/* File: hdl/slp_consts.svh */
`ifndef SLP_CONSTS_SVH
`define SLP_CONSTS_SVH

// ****************************************
// register byte addresses
// ****************************************
`define SLP_ADDR_LOCK_STATUS 8'hB9
`define SLP_ADDR_LOCK_CLEAR 8'hBA
`define SLP_ADDR_PREC_C_HI 8'hBF
`define SLP_ADDR_PREC_C_LO 8'hC0
`define SLP_ADDR_PREC_D_HI 8'hC1
`define SLP_ADDR_PREC_D_LO 8'hC2
`define SLP_ADDR_OSC_SEL 8'hC3
`define SLP_ADDR_REV_LOW 8'hC6
`define SLP_ADDR_GEN_A_HI 8'hCB
`define SLP_ADDR_GEN_A_LO 8'hCC

// ****************************************
// field positions
// ****************************************
`define SLP_PREC_FLD_LSB 0
`define SLP_GEN_FLD_LSB 2
`define SLP_COARSE_MSB 12
`define SLP_QUAD_MSB 15
`define SLP_QUAD_LSB 13
`define SLP_OSC_SEL_BIT 0

// ****************************************
// reset values and codes
// ****************************************
`define SLP_LOCK_RST_VAL 2'h3
`define SLP_CLEAR_CODE 2'h3
`define SLP_CLEAR_RST_VAL 2'h0
`define SLP_PHASE_RST_VAL 16'h0000
`define SLP_OSC_RST_VAL 1'h0
`define SLP_READ_ZERO 8'h00

`endif

/* File: hdl/slp_pkg.sv */
`default_nettype none
package slp_pkg;

    // byte request from the serial configuration port engine
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } slp_reg_req_t;

    // settings handed to one post divider
    typedef struct packed {
        logic signed [12:0] coarse;
        logic signed [3:0] quad_steps;
        logic update;
    } slp_phase_cfg_t;

    // quadrature code to signed count of 45 degree steps
    function automatic logic signed [3:0] slp_quad_steps(input logic [2:0] code);
        case (code)
            3'h0: slp_quad_steps = 4'sh0;
            3'h1: slp_quad_steps = -4'sh1;
            3'h2: slp_quad_steps = -4'sh2;
            3'h3: slp_quad_steps = -4'sh3;
            3'h4: slp_quad_steps = 4'sh4;
            3'h5: slp_quad_steps = 4'sh3;
            3'h6: slp_quad_steps = 4'sh2;
            default: slp_quad_steps = 4'sh1;
        endcase
    endfunction

endpackage
`default_nettype wire

/* File: hdl/slp_lock_flag.sv */
`timescale 1ns/10ps
`default_nettype none
`include "slp_consts.svh"

module slp_lock_flag (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // synthesizer event and software clear
    input wire logic [1:0] lost,
    input wire logic clear_cmd,
    // sticky field
    output logic [1:0] flag_ff
);

    logic [1:0] nxt_flag;

    // clear first, then or in new events so a same-cycle loss survives
    always_comb begin
        nxt_flag = clear_cmd ? 2'h0 : flag_ff;
        nxt_flag = nxt_flag | lost;
    end

    // flag comes up set out of reset, software must clear it first
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            flag_ff <= `SLP_LOCK_RST_VAL;
        end else begin
            flag_ff <= nxt_flag;
        end
    end

endmodule // slp_lock_flag
`default_nettype wire

/* File: hdl/slp_phase_reg.sv */
`timescale 1ns/10ps
`default_nettype none
`include "slp_consts.svh"

module slp_phase_reg (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // byte writes
    input wire logic wr_hi,
    input wire logic wr_lo,
    input wire logic [7:0] wdata,
    // stored word and divider settings
    output logic [15:0] value_ff,
    output slp_pkg::slp_phase_cfg_t cfg_ff
);

    logic [15:0] nxt_value;

    // lower address carries bits 15:8, higher address bits 7:0
    always_comb begin
        nxt_value = value_ff;
        if (wr_hi) begin
            nxt_value[15:8] = wdata;
        end
        if (wr_lo) begin
            nxt_value[7:0] = wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            value_ff <= `SLP_PHASE_RST_VAL;
        end else begin
            value_ff <= nxt_value;
        end
    end

    // divider view takes each byte at the same edge as the word; update marks a fresh value
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cfg_ff <= '0;
        end else begin
            cfg_ff.coarse <= nxt_value[`SLP_COARSE_MSB:0];
            cfg_ff.quad_steps <= slp_pkg::slp_quad_steps(nxt_value[`SLP_QUAD_MSB:`SLP_QUAD_LSB]);
            cfg_ff.update <= wr_hi | wr_lo;
        end
    end

endmodule // slp_phase_reg
`default_nettype wire

/* File: hdl/slp_lock_phase_regs.sv */
`timescale 1ns/10ps
`default_nettype none
`include "slp_consts.svh"

module slp_lock_phase_regs #(
    // revision byte after reset; the value is arbitrary
    parameter logic [7:0] REV_LOW_RST = 8'h5A
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // byte access from the serial configuration port
    input wire slp_pkg::slp_reg_req_t reg_req,
    output logic [7:0] reg_rdata_ff,
    output logic reg_rvalid_ff,
    output logic reg_unmapped_ff,
    // synthesizer lock monitors
    input wire logic [1:0] precision_lock_lost,
    input wire logic [1:0] general_lock_lost,
    // revision bits held in the identity register
    input wire logic [1:0] chip_revision_upper,
    // lock-loss status towards the rest of the device
    output logic [1:0] precision_lock_loss,
    output logic [1:0] general_lock_loss,
    // post divider phase settings
    output slp_pkg::slp_phase_cfg_t precision_div_c_phase,
    output slp_pkg::slp_phase_cfg_t precision_div_d_phase,
    output slp_pkg::slp_phase_cfg_t general_div_a_phase,
    // oscillator output driver and revision
    output logic oscillator_out_driver_en_ff,
    output logic [9:0] full_revision_ff
);

    // ****************************************
    // address decode
    // ****************************************

    // one byte address against one register
    function automatic logic slp_hit(input logic [7:0] addr, input logic [7:0] target);
        slp_hit = (addr == target);
    endfunction

    // every address this bank answers to
    function automatic logic slp_mapped(input logic [7:0] addr);
        case (addr)
            `SLP_ADDR_LOCK_STATUS,
            `SLP_ADDR_LOCK_CLEAR,
            `SLP_ADDR_PREC_C_HI,
            `SLP_ADDR_PREC_C_LO,
            `SLP_ADDR_PREC_D_HI,
            `SLP_ADDR_PREC_D_LO,
            `SLP_ADDR_OSC_SEL,
            `SLP_ADDR_REV_LOW,
            `SLP_ADDR_GEN_A_HI,
            `SLP_ADDR_GEN_A_LO: slp_mapped = 1'b1;
            default: slp_mapped = 1'b0;
        endcase
    endfunction

    logic wr_clear;
    logic wr_prec_c_hi;
    logic wr_prec_c_lo;
    logic wr_prec_d_hi;
    logic wr_prec_d_lo;
    logic wr_osc;
    logic wr_rev;
    logic wr_gen_a_hi;
    logic wr_gen_a_lo;

    // write strobes, one per byte address except the read-only lock status
    assign wr_clear = reg_req.wr & slp_hit(reg_req.addr, `SLP_ADDR_LOCK_CLEAR);
    assign wr_prec_c_hi = reg_req.wr & slp_hit(reg_req.addr, `SLP_ADDR_PREC_C_HI);
    assign wr_prec_c_lo = reg_req.wr & slp_hit(reg_req.addr, `SLP_ADDR_PREC_C_LO);
    assign wr_prec_d_hi = reg_req.wr & slp_hit(reg_req.addr, `SLP_ADDR_PREC_D_HI);
    assign wr_prec_d_lo = reg_req.wr & slp_hit(reg_req.addr, `SLP_ADDR_PREC_D_LO);
    assign wr_osc = reg_req.wr & slp_hit(reg_req.addr, `SLP_ADDR_OSC_SEL);
    assign wr_rev = reg_req.wr & slp_hit(reg_req.addr, `SLP_ADDR_REV_LOW);
    assign wr_gen_a_hi = reg_req.wr & slp_hit(reg_req.addr, `SLP_ADDR_GEN_A_HI);
    assign wr_gen_a_lo = reg_req.wr & slp_hit(reg_req.addr, `SLP_ADDR_GEN_A_LO);

    // ****************************************
    // lock-loss clear control
    // ****************************************

    logic [1:0] prec_clear_ff;
    logic [1:0] gen_clear_ff;

    // only bits 3:0 are stored; reserved upper bits read back as zero
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prec_clear_ff <= `SLP_CLEAR_RST_VAL;
            gen_clear_ff <= `SLP_CLEAR_RST_VAL;
        end else if (wr_clear) begin
            prec_clear_ff <= reg_req.wdata[`SLP_PREC_FLD_LSB +: 2];
            gen_clear_ff <= reg_req.wdata[`SLP_GEN_FLD_LSB +: 2];
        end
    end

    logic prec_clear_cmd;
    logic gen_clear_cmd;

    // the clear acts as long as the code stays; software must write zero back
    assign prec_clear_cmd = (prec_clear_ff == `SLP_CLEAR_CODE);
    assign gen_clear_cmd = (gen_clear_ff == `SLP_CLEAR_CODE);

    // ****************************************
    // sticky lock-loss status
    // ****************************************

    // a loss in the clearing cycle still lands, set beats clear
    slp_lock_flag u_prec_flag (
        .clk(clk),
        .rst_n(rst_n),
        .lost(precision_lock_lost),
        .clear_cmd(prec_clear_cmd),
        .flag_ff(precision_lock_loss)
    );

    // same field for the general synthesizer at bits 3:2
    slp_lock_flag u_gen_flag (
        .clk(clk),
        .rst_n(rst_n),
        .lost(general_lock_lost),
        .clear_cmd(gen_clear_cmd),
        .flag_ff(general_lock_loss)
    );

    // ****************************************
    // phase registers
    // ****************************************

    logic [15:0] prec_c_word;
    logic [15:0] prec_d_word;
    logic [15:0] gen_a_word;

    // precision synthesizer, post divider c
    slp_phase_reg u_prec_c (
        .clk(clk),
        .rst_n(rst_n),
        .wr_hi(wr_prec_c_hi),
        .wr_lo(wr_prec_c_lo),
        .wdata(reg_req.wdata),
        .value_ff(prec_c_word),
        .cfg_ff(precision_div_c_phase)
    );

    // precision synthesizer, post divider d
    slp_phase_reg u_prec_d (
        .clk(clk),
        .rst_n(rst_n),
        .wr_hi(wr_prec_d_hi),
        .wr_lo(wr_prec_d_lo),
        .wdata(reg_req.wdata),
        .value_ff(prec_d_word),
        .cfg_ff(precision_div_d_phase)
    );

    // general synthesizer, post divider a
    slp_phase_reg u_gen_a (
        .clk(clk),
        .rst_n(rst_n),
        .wr_hi(wr_gen_a_hi),
        .wr_lo(wr_gen_a_lo),
        .wdata(reg_req.wdata),
        .value_ff(gen_a_word),
        .cfg_ff(general_div_a_phase)
    );

    // ****************************************
    // oscillator select
    // ****************************************

    logic osc_sel_ff;

    // one means an external oscillator feeds the master clock
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            osc_sel_ff <= `SLP_OSC_RST_VAL;
        end else if (wr_osc) begin
            osc_sel_ff <= reg_req.wdata[`SLP_OSC_SEL_BIT];
        end
    end

    // driver runs while the select bit is zero (crystal in use)
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            oscillator_out_driver_en_ff <= ~`SLP_OSC_RST_VAL;
        end else begin
            oscillator_out_driver_en_ff <= ~osc_sel_ff;
        end
    end

    // ****************************************
    // revision
    // ****************************************

    logic [7:0] rev_low_ff;

    // writable byte; a write changes what the full revision reports
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rev_low_ff <= REV_LOW_RST;
        end else if (wr_rev) begin
            rev_low_ff <= reg_req.wdata;
        end
    end

    // upper bits come from the identity register and are sampled each cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            full_revision_ff <= 10'h000;
        end else begin
            full_revision_ff <= {chip_revision_upper, rev_low_ff};
        end
    end

    // ****************************************
    // read back
    // ****************************************

    logic [7:0] nxt_rdata;

    // reserved bits and unmapped addresses read as zero
    always_comb begin
        nxt_rdata = `SLP_READ_ZERO;
        case (reg_req.addr)
            `SLP_ADDR_LOCK_STATUS: nxt_rdata = {4'h0, general_lock_loss, precision_lock_loss};
            `SLP_ADDR_LOCK_CLEAR: nxt_rdata = {4'h0, gen_clear_ff, prec_clear_ff};
            `SLP_ADDR_PREC_C_HI: nxt_rdata = prec_c_word[15:8];
            `SLP_ADDR_PREC_C_LO: nxt_rdata = prec_c_word[7:0];
            `SLP_ADDR_PREC_D_HI: nxt_rdata = prec_d_word[15:8];
            `SLP_ADDR_PREC_D_LO: nxt_rdata = prec_d_word[7:0];
            `SLP_ADDR_OSC_SEL: nxt_rdata = {7'h00, osc_sel_ff};
            `SLP_ADDR_REV_LOW: nxt_rdata = rev_low_ff;
            `SLP_ADDR_GEN_A_HI: nxt_rdata = gen_a_word[15:8];
            `SLP_ADDR_GEN_A_LO: nxt_rdata = gen_a_word[7:0];
            default: nxt_rdata = `SLP_READ_ZERO;
        endcase
    end

    // read data is held until the next read
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            reg_rdata_ff <= `SLP_READ_ZERO;
        end else if (reg_req.rd) begin
            reg_rdata_ff <= nxt_rdata;
        end
    end

    // one-cycle marker that reg_rdata_ff carries a fresh byte
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            reg_rvalid_ff <= 1'b0;
        end else begin
            reg_rvalid_ff <= reg_req.rd;
        end
    end

    // flags an access to an address outside this bank; writes there are dropped
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            reg_unmapped_ff <= 1'b0;
        end else begin
            reg_unmapped_ff <= (reg_req.rd | reg_req.wr) & ~slp_mapped(reg_req.addr);
        end
    end

endmodule // slp_lock_phase_regs
`default_nettype wire

/* File: sim/slp_lock_phase_regs_properties.sv */
`timescale 1ns/10ps
`default_nettype none
`include "slp_consts.svh"

// ****************************************
// port checker
// ****************************************
module slp_lock_phase_regs_checker #(
    // revision byte after reset; the value is arbitrary
    parameter logic [7:0] REV_LOW_RST = 8'h5A
) (
    // clock, reset and register bus
    input wire logic clk,
    input wire logic rst_n,
    input wire slp_pkg::slp_reg_req_t reg_req,
    input wire logic [7:0] reg_rdata_ff,
    input wire logic reg_rvalid_ff,
    input wire logic reg_unmapped_ff,
    // lock monitors and revision
    input wire logic [1:0] precision_lock_lost,
    input wire logic [1:0] general_lock_lost,
    input wire logic [1:0] chip_revision_upper,
    // outputs towards the device
    input wire logic [1:0] precision_lock_loss,
    input wire logic [1:0] general_lock_loss,
    input wire slp_pkg::slp_phase_cfg_t precision_div_c_phase,
    input wire slp_pkg::slp_phase_cfg_t precision_div_d_phase,
    input wire slp_pkg::slp_phase_cfg_t general_div_a_phase,
    input wire logic oscillator_out_driver_en_ff,
    input wire logic [9:0] full_revision_ff
);
    logic clr_p_ff;
    logic clr_g_ff;
    logic [3:0] lost_all;
    logic [3:0] loss_all;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    // both synthesizers side by side
    assign lost_all = {general_lock_lost, precision_lock_lost};
    assign loss_all = {general_lock_loss, precision_lock_loss};

    // mirror of the clear fields, so a falling flag can be told from a legal clear
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            clr_p_ff <= 1'b0;
            clr_g_ff <= 1'b0;
        end else if (reg_req.wr && reg_req.addr == `SLP_ADDR_LOCK_CLEAR) begin
            clr_p_ff <= reg_req.wdata[1:0] == 2'h3;
            clr_g_ff <= reg_req.wdata[3:2] == 2'h3;
        end
    end

    chk_read_status:
    assert property (reg_req.rd && reg_req.addr == `SLP_ADDR_LOCK_STATUS |=>
        reg_rdata_ff == {4'h0, $past(general_lock_loss), $past(precision_lock_loss)}) else $error("bad status read");
    chk_lock_set:
    assert property (lost_all != 4'h0 |=> (loss_all & $past(lost_all)) == $past(lost_all))
        else $error("loss event not flagged");
    chk_prec_sticky:
    assert property (!clr_p_ff |=> (precision_lock_loss | ~$past(precision_lock_loss)) == 2'h3)
        else $error("precision flag dropped");
    chk_gen_sticky:
    assert property (!clr_g_ff |=> (general_lock_loss | ~$past(general_lock_loss)) == 2'h3)
        else $error("general flag dropped");
    chk_prec_clear:
    assert property (clr_p_ff && precision_lock_lost == 2'h0 |=> precision_lock_loss == 2'h0)
        else $error("clear code ignored");
    chk_reset_sets:
    assert property ($rose(rst_n) |-> loss_all == 4'hF) else $error("flags not set by reset");
    chk_phase_high:
    assert property (reg_req.wr && reg_req.addr == `SLP_ADDR_PREC_C_HI |=> precision_div_c_phase.update
        && {3'h0, precision_div_c_phase.coarse[12:8]} == ($past(reg_req.wdata) & 8'h1F)) else $error("bad high byte");
    chk_phase_low:
    assert property (reg_req.wr && reg_req.addr == `SLP_ADDR_PREC_D_LO |=>
        precision_div_d_phase.coarse[7:0] == $past(reg_req.wdata)) else $error("bad low byte");
    chk_osc_driver:
    assert property (reg_req.wr && reg_req.addr == `SLP_ADDR_OSC_SEL |-> ##2
        {7'h0, oscillator_out_driver_en_ff} == (~$past(reg_req.wdata, 2) & 8'h01)) else $error("bad driver enable");
    chk_rev_upper:
    assert property ($past(rst_n) |-> full_revision_ff[9:8] == $past(chip_revision_upper))
        else $error("revision bits stale");
endmodule // slp_lock_phase_regs_checker

bind slp_lock_phase_regs slp_lock_phase_regs_checker #(.REV_LOW_RST(REV_LOW_RST)) i_chk (.clk, .rst_n, .reg_req,
    .reg_rdata_ff, .reg_rvalid_ff, .reg_unmapped_ff, .precision_lock_lost, .general_lock_lost, .chip_revision_upper,
    .precision_lock_loss, .general_lock_loss, .precision_div_c_phase, .precision_div_d_phase, .general_div_a_phase,
    .oscillator_out_driver_en_ff, .full_revision_ff);
`default_nettype wire

/* File: sim/test_slp_lock_phase_regs.sv */
`timescale 1ns/10ps
`default_nettype none
`include "slp_consts.svh"

module test_slp_lock_phase_regs;
    localparam logic [7:0] REV = 8'hA5; // arbitrary revision byte
    logic clk;
    logic rst_n;
    slp_pkg::slp_reg_req_t reg_req;
    logic [7:0] reg_rdata_ff;
    logic reg_rvalid_ff;
    logic reg_unmapped_ff;
    logic [1:0] p_lost;
    logic [1:0] g_lost;
    logic [1:0] rev_up;
    logic [1:0] precision_lock_loss;
    logic [1:0] general_lock_loss;
    slp_pkg::slp_phase_cfg_t cfg [3];
    logic drv_en;
    logic [9:0] full_rev;
    logic [8:0] exp_q [$];
    int err_count;
    int compares;
    logic [7:0] hi_addr [3] = '{`SLP_ADDR_PREC_C_HI, `SLP_ADDR_PREC_D_HI, `SLP_ADDR_GEN_A_HI};
    logic signed [3:0] quad_exp [8] = '{4'sh0, -4'sh1, -4'sh2, -4'sh3, 4'sh4, 4'sh3, 4'sh2, 4'sh1};
    logic [15:0] word [3];
    logic [7:0] rev;
    logic [1:0] lp;
    logic [1:0] lg;

    slp_lock_phase_regs #(.REV_LOW_RST(REV)) i_dut (.clk, .rst_n, .reg_req, .reg_rdata_ff, .reg_rvalid_ff,
        .reg_unmapped_ff, .precision_lock_lost(p_lost), .general_lock_lost(g_lost), .chip_revision_upper(rev_up),
        .precision_lock_loss, .general_lock_loss, .precision_div_c_phase(cfg[0]), .precision_div_d_phase(cfg[1]),
        .general_div_a_phase(cfg[2]), .oscillator_out_driver_en_ff(drv_en), .full_revision_ff(full_rev));

    // ****************************************
    // clock, bus tasks and comparisons
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // one-cycle access; a read leaves its expected {unmapped, byte} for the monitor
    task automatic acc(input logic w, input logic [7:0] a, input logic [8:0] v);
        @(negedge clk);
        reg_req <= '{addr: a, wdata: v[7:0], wr: w, rd: !w};
        if (!w) exp_q.push_back(v);
    endtask

    task automatic idle(input int n);
        @(negedge clk);
        reg_req <= '0;
        repeat (n) @(negedge clk);
    endtask

    task automatic do_reset;
        @(negedge clk);
        rst_n <= 1'b0;
        repeat (3) @(negedge clk);
        rst_n <= 1'b1;
    endtask

    task automatic cmp_rd(input logic [8:0] got, input logic [8:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: read %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: port %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic give_verdict;
        if (exp_q.size() != 0) err_count++;
        $display("compares %0d, errors %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // monitor: each answered read takes the oldest note, looked at mid-cycle while rvalid stands
    always @(negedge clk) begin
        if (reg_rvalid_ff === 1'b1) begin
            if (exp_q.size() == 0) begin
                err_count++;
                $display("wrong value at %0t: unexpected read answer", $time);
            end else begin
                cmp_rd({reg_unmapped_ff, reg_rdata_ff}, exp_q.pop_front());
            end
        end
    end

    // watchdog: a stalled sequence still ends with a verdict
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        give_verdict();
    end

    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        rst_n = 1'b0;
        reg_req = '0;
        p_lost = 2'h0;
        g_lost = 2'h0;
        err_count = 0;
        compares = 0;
        void'($urandom(29));
        rev_up = 2'($urandom);
        do_reset();
        acc(0, `SLP_ADDR_LOCK_STATUS, 9'h00F);
        acc(0, `SLP_ADDR_LOCK_CLEAR, 9'h000);
        acc(0, `SLP_ADDR_PREC_C_HI, 9'h000);
        acc(0, `SLP_ADDR_OSC_SEL, 9'h000);
        acc(0, `SLP_ADDR_REV_LOW, {1'b0, REV});
        idle(1);
        cmp_val(16'(drv_en), 16'h0001);
        cmp_val(16'(full_rev), 16'({rev_up, REV}));
        // clear one synthesizer at a time, the other must stay flagged
        acc(1, `SLP_ADDR_LOCK_CLEAR, 9'h003);
        acc(1, `SLP_ADDR_LOCK_CLEAR, 9'h000);
        idle(1);
        acc(0, `SLP_ADDR_LOCK_STATUS, 9'h00C);
        acc(1, `SLP_ADDR_LOCK_CLEAR, 9'h00C);
        acc(1, `SLP_ADDR_LOCK_CLEAR, 9'h000);
        idle(1);
        acc(0, `SLP_ADDR_LOCK_STATUS, 9'h000);
        // short loss pulses stay flagged through codes that are not a clear
        for (int i = 0; i < 4; i++) begin
            lp = 2'($urandom_range(1, 3));
            lg = 2'($urandom_range(1, 3));
            @(negedge clk);
            reg_req <= '0; // the last status read must not repeat
            p_lost <= lp;
            g_lost <= lg;
            @(negedge clk);
            p_lost <= 2'h0;
            g_lost <= 2'h0;
            acc(1, `SLP_ADDR_LOCK_CLEAR, {5'h0, 2'($urandom_range(0, 2)), 2'($urandom_range(0, 2))});
            idle(2);
            acc(0, `SLP_ADDR_LOCK_STATUS, {5'h0, lg, lp});
            acc(1, `SLP_ADDR_LOCK_CLEAR, 9'h00F);
            acc(1, `SLP_ADDR_LOCK_CLEAR, 9'h000);
            idle(1);
            acc(0, `SLP_ADDR_LOCK_STATUS, 9'h000);
        end
        // three post dividers written back to back, each kept apart
        for (int i = 0; i < 3; i++) begin
            word[i] = 16'($urandom);
            acc(1, hi_addr[i], {1'b0, word[i][15:8]});
            acc(1, hi_addr[i] + 8'h01, {1'b0, word[i][7:0]});
        end
        idle(2);
        for (int i = 0; i < 3; i++) begin
            cmp_val(16'(cfg[i].coarse), 16'(signed'(word[i][12:0])));
            acc(0, hi_addr[i], {1'b0, word[i][15:8]});
            acc(0, hi_addr[i] + 8'h01, {1'b0, word[i][7:0]});
        end
        // every quadrature code
        for (int c = 0; c < 8; c++) begin
            acc(1, `SLP_ADDR_GEN_A_HI, {1'b0, 3'(c), 5'h00});
            idle(2);
            cmp_val(16'(cfg[2].quad_steps), 16'(quad_exp[c]));
        end
        // driver select, reserved bits read as zero
        acc(1, `SLP_ADDR_OSC_SEL, 9'h0FF); // external oscillator
        idle(2);
        cmp_val(16'(drv_en), 16'h0000);
        acc(0, `SLP_ADDR_OSC_SEL, 9'h001);
        acc(1, `SLP_ADDR_OSC_SEL, 9'h000); // crystal
        idle(2);
        cmp_val(16'(drv_en), 16'h0001);
        // writable revision, read-only status, unmapped hole
        rev = 8'($urandom);
        rev_up <= 2'($urandom);
        acc(1, `SLP_ADDR_REV_LOW, {1'b0, rev});
        acc(1, `SLP_ADDR_LOCK_STATUS, 9'h00F);
        acc(0, 8'hC4, 9'h100);
        acc(0, `SLP_ADDR_LOCK_STATUS, 9'h000);
        acc(0, `SLP_ADDR_REV_LOW, {1'b0, rev});
        idle(2);
        cmp_val(16'(full_rev), 16'({rev_up, rev}));
        // second reset in mid-run
        do_reset();
        acc(0, `SLP_ADDR_LOCK_STATUS, 9'h00F);
        acc(0, `SLP_ADDR_GEN_A_HI, 9'h000);
        acc(0, `SLP_ADDR_OSC_SEL, 9'h000);
        idle(2);
        give_verdict();
    end
endmodule // test_slp_lock_phase_regs
`default_nettype wire
